// File: hw/bmr_top.sv
// Decided for this implementation: the register offsets and the strobed register port.
module bmr_top #(
	parameter logic [3:0] REVISION    = 4'h1,  // arbitrary revision code
	parameter bit         ROM_VARIANT = 1'b0   // mask ROM part: code lives in ROM
) (
	input  wire logic        ref_clk,        // core clock
	input  wire logic        rst,            // power-up or function reset
	input  wire logic        clk_en,         // freezes all state while low
	input  wire logic [7:0]  reg_addr,       // register address (low byte)
	input  wire logic [7:0]  reg_wdata,      // register write data
	input  wire logic        reg_wr,         // register write strobe
	input  wire logic        reg_rd,         // register read strobe
	output logic      [7:0]  reg_rdata,      // read data, cycle after strobe
	input  wire logic [15:0] code_addr,      // core code fetch address
	input  wire logic        code_req,       // core code fetch strobe
	input  wire logic [15:0] data_addr,      // core data address
	input  wire logic        data_rd,        // core data read strobe
	input  wire logic        data_wr,        // core data write strobe
	input  wire logic        eeprom_sig_ok,  // boot code found EEPROM signature
	input  wire logic        load_done,      // boot code finished loading
	output logic             rom_sel,        // ROM selected for code
	output logic             code_ram_sel,   // RAM selected for code
	output logic             data_ram_sel,   // RAM selected for data
	output logic             data_ram_we,    // RAM write enable
	output logic             io_sel,         // buffer / register / I/O window
	output logic [12:0]      mem_addr,       // offset into selected memory
	output logic             boot_map_switch, // map switch state
	output logic             bus_attach,     // USB attach state
	output logic             boot_from_usb,  // loader source is USB
	output logic [2:0]       boot_phase      // boot sequence state
);

	// ==========================================
	// Register state
	logic                   map_q,    map_d;
	logic [7:0]             cfg_q,    cfg_d;
	logic [7:0]             ctl_q,    ctl_d;
	logic [7:0]             rdata_q,  rdata_d;
	logic                   usb_src_q, usb_src_d;
	bmr_pkg::bmr_boot_type  boot_q,   boot_d;

	wire logic cfg_hit;
	wire logic ctl_hit;
	wire logic map_set;
	wire logic map_eff;
	wire logic attach_req;
	wire logic [7:0] cfg_view;
	wire logic [7:0] ctl_view;

	assign cfg_hit = reg_addr == bmr_pkg::CFG_REG_ADDR;
	assign ctl_hit = reg_addr == bmr_pkg::CTL_REG_ADDR;

	// A one sets the switch; zero leaves it, so it can only go back by reset
	assign map_set = reg_wr && cfg_hit && reg_wdata[bmr_pkg::MAP_SWITCH_BIT];
	assign map_d   = map_q | map_set;

	// Attach is ignored while still in boot mode, so the host never sees boot code
	assign attach_req = reg_wr && ctl_hit && map_q;
	assign ctl_d      = attach_req ? (reg_wdata & bmr_pkg::CTL_WR_MASK) |
	                                 (reg_wdata & ~bmr_pkg::CTL_WR_MASK) :
	                    (reg_wr && ctl_hit) ? (reg_wdata & bmr_pkg::CTL_WR_MASK) |
	                                          (ctl_q & ~bmr_pkg::CTL_WR_MASK) :
	                    ctl_q;

	assign cfg_d = (reg_wr && cfg_hit) ? (reg_wdata & bmr_pkg::CFG_WR_MASK) : cfg_q;

	// Revision field forced in, bit 5 masked, bit 0 shows the map switch, stored bits 7:6 pass through
	assign cfg_view = {cfg_q[7:6], 1'b0, REVISION, map_q};
	assign ctl_view = ctl_q;

	assign rdata_d = !reg_rd ? 8'h00 :
	                 cfg_hit ? cfg_view :
	                 ctl_hit ? ctl_view :
	                 8'h00;

	// ==========================================
	// Boot sequence tracking
	assign usb_src_d = (boot_q == bmr_pkg::BS_FETCH && code_req) ? ~eeprom_sig_ok : usb_src_q;

	always_comb begin
		boot_d = boot_q;
		unique case (boot_q)
			bmr_pkg::BS_FETCH: begin
				if (code_req) begin
					boot_d = bmr_pkg::BS_LOAD;
				end
			end
			bmr_pkg::BS_LOAD: begin
				if (load_done || map_q) begin
					boot_d = bmr_pkg::BS_SWITCH;
				end
			end
			bmr_pkg::BS_SWITCH: begin
				if (map_q) begin
					boot_d = bmr_pkg::BS_ATTACH;
				end
			end
			bmr_pkg::BS_ATTACH: begin
				if (ctl_q[bmr_pkg::ATTACH_BIT]) begin
					boot_d = bmr_pkg::BS_RUN;
				end
			end
			bmr_pkg::BS_RUN: begin
				boot_d = bmr_pkg::BS_RUN;
			end
			default: begin
				boot_d = bmr_pkg::BS_FETCH;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			map_q     <= 1'b0;
			ctl_q     <= 8'h00;
			cfg_q     <= 8'h00;
			rdata_q   <= 8'h00;
			usb_src_q <= 1'b0;
			boot_q    <= bmr_pkg::BS_FETCH;
		end else if (clk_en) begin
			map_q     <= map_d;
			ctl_q     <= ctl_d;
			cfg_q     <= cfg_d;
			rdata_q   <= rdata_d;
			usb_src_q <= usb_src_d;
			boot_q    <= boot_d;
		end
	end

	// ==========================================
	// Address decode
	bmr_pkg::bmr_target_type code_tgt;
	bmr_pkg::bmr_target_type data_tgt;

	// Mask ROM part keeps boot map decode; code RAM would hold nothing useful there
	assign map_eff = map_q && !ROM_VARIANT;

	bmr_decode u_decode (
		.code_addr  (code_addr),
		.data_addr  (data_addr),
		.map_normal (map_eff),
		.code_tgt   (code_tgt),
		.data_tgt   (data_tgt)
	);

	wire logic        rom_d;
	wire logic        cram_d;
	wire logic        dram_d;
	wire logic        we_d;
	wire logic        io_d;
	wire logic [12:0] addr_d;

	assign rom_d  = code_req && code_tgt == bmr_pkg::TGT_ROM;
	assign cram_d = code_req && code_tgt == bmr_pkg::TGT_RAM;
	assign dram_d = (data_rd || data_wr) && data_tgt == bmr_pkg::TGT_RAM;
	// Code RAM has no data path in normal mode, so no write can reach it
	assign we_d   = data_wr && data_tgt == bmr_pkg::TGT_RAM && !map_eff;
	assign io_d   = (data_rd || data_wr) && data_tgt == bmr_pkg::TGT_IO;
	assign addr_d = code_req ? code_addr[12:0] : data_addr[12:0];

	logic        rom_q, cram_q, dram_q, we_q, io_q;
	logic [12:0] addr_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rom_q  <= 1'b0;
			cram_q <= 1'b0;
			dram_q <= 1'b0;
			we_q   <= 1'b0;
			io_q   <= 1'b0;
			addr_q <= 13'h0000;
		end else if (clk_en) begin
			rom_q  <= rom_d;
			cram_q <= cram_d;
			dram_q <= dram_d;
			we_q   <= we_d;
			io_q   <= io_d;
			addr_q <= addr_d;
		end
	end

	assign reg_rdata       = rdata_q;
	assign rom_sel         = rom_q;
	assign code_ram_sel    = cram_q;
	assign data_ram_sel    = dram_q;
	assign data_ram_we     = we_q;
	assign io_sel          = io_q;
	assign mem_addr        = addr_q;
	assign boot_map_switch = map_q;
	assign bus_attach      = ctl_q[bmr_pkg::ATTACH_BIT];
	assign boot_from_usb   = usb_src_q;
	assign boot_phase      = boot_q;

endmodule // bmr_top

// File: pkg/bmr_pkg.sv
package bmr_pkg;

	// ==========================================
	// Register map
	localparam logic [7:0] CFG_REG_ADDR    = 8'h90;  // low byte of the mapped register window
	localparam logic [7:0] CTL_REG_ADDR    = 8'h91;  // host link control (attach)
	localparam int         MAP_SWITCH_BIT  = 0;
	localparam int         REV_LSB         = 1;
	localparam int         REV_MSB         = 4;
	localparam int         ATTACH_BIT      = 7;
	localparam logic [7:0] CFG_WR_MASK     = 8'hc0;  // clock select and interrupt source bits
	localparam logic [7:0] CTL_WR_MASK     = 8'h7f;  // other link control bits, stored only

	// ==========================================
	// Address windows
	localparam logic [15:0] ROM_LO_BASE    = 16'h0000;
	localparam logic [15:0] ROM_LO_TOP     = 16'h17ff;
	localparam logic [15:0] ROM_HI_BASE    = 16'h8000;
	localparam logic [15:0] ROM_HI_TOP     = 16'h97ff;
	localparam logic [15:0] RAM_BASE       = 16'h0000;
	localparam logic [15:0] RAM_TOP        = 16'h1fff;
	localparam logic [15:0] IO_BASE        = 16'hfd80;
	localparam logic [15:0] IO_TOP         = 16'hffff;
	localparam logic [15:0] RESET_VECTOR   = 16'h0000;

	// ==========================================
	// Decode targets
	typedef enum logic [2:0] {
		TGT_NONE = 3'b000,
		TGT_ROM  = 3'b001,
		TGT_RAM  = 3'b010,
		TGT_IO   = 3'b011
	} bmr_target_type;

	// ==========================================
	// Boot sequence
	typedef enum logic [2:0] {
		BS_FETCH  = 3'b000,
		BS_LOAD   = 3'b001,
		BS_SWITCH = 3'b010,
		BS_ATTACH = 3'b011,
		BS_RUN    = 3'b100
	} bmr_boot_type;

	function automatic logic bmr_in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

endpackage

// File: hw/bmr_decode.sv
module bmr_decode (
	input  wire logic [15:0]             code_addr,   // code fetch address
	input  wire logic [15:0]             data_addr,   // data access address
	input  wire logic                    map_normal,  // map switch as seen by decode
	output bmr_pkg::bmr_target_type      code_tgt,    // code space target
	output bmr_pkg::bmr_target_type      data_tgt     // data space target
);

	wire logic code_rom_lo;
	wire logic code_rom_hi;
	wire logic code_ram;
	wire logic data_ram;
	wire logic data_io;

	assign code_rom_lo = bmr_pkg::bmr_in_range(code_addr, bmr_pkg::ROM_LO_BASE, bmr_pkg::ROM_LO_TOP);
	assign code_rom_hi = bmr_pkg::bmr_in_range(code_addr, bmr_pkg::ROM_HI_BASE, bmr_pkg::ROM_HI_TOP);
	assign code_ram    = bmr_pkg::bmr_in_range(code_addr, bmr_pkg::RAM_BASE, bmr_pkg::RAM_TOP);
	assign data_ram    = bmr_pkg::bmr_in_range(data_addr, bmr_pkg::RAM_BASE, bmr_pkg::RAM_TOP);
	assign data_io     = bmr_pkg::bmr_in_range(data_addr, bmr_pkg::IO_BASE, bmr_pkg::IO_TOP);

	// Boot: ROM low and mirrored high; normal: RAM low, ROM high only
	assign code_tgt = code_rom_hi                ? bmr_pkg::TGT_ROM :
	                  (map_normal && code_ram)   ? bmr_pkg::TGT_RAM :
	                  (!map_normal && code_rom_lo) ? bmr_pkg::TGT_ROM :
	                  bmr_pkg::TGT_NONE;

	assign data_tgt = data_io                  ? bmr_pkg::TGT_IO  :
	                  (!map_normal && data_ram) ? bmr_pkg::TGT_RAM :
	                  bmr_pkg::TGT_NONE;

endmodule // bmr_decode

// File: dv/bmr_top_props.sv
module bmr_top_props #(
	parameter logic [3:0] REVISION = 4'h1  // revision under test
) (
	input wire logic        ref_clk, rst, clk_en, reg_rd, code_req, data_rd, data_wr, // controls
	input wire logic [7:0]  reg_addr, reg_rdata,                                       // register bus
	input wire logic [15:0] code_addr, data_addr,                                      // core addresses
	input wire logic        rom_sel, code_ram_sel, data_ram_sel, data_ram_we, io_sel,  // selects
	input wire logic        boot_map_switch, bus_attach                                // state
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire code_go = code_req && clk_en;
	wire data_go = (data_rd || data_wr) && clk_en;
	// ==========================================
	// Decode
	a_rom_boot_low: assert property (code_go && !boot_map_switch && code_addr <= 16'h17ff |=> rom_sel)
		else $error("low code fetch missed ROM in boot mode");
	a_rom_high_any: assert property (code_go && code_addr >= 16'h8000 && code_addr <= 16'h97ff |=> rom_sel)
		else $error("high code fetch missed ROM");
	a_code_ram_norm: assert property (code_go && boot_map_switch && code_addr <= 16'h1fff |=> code_ram_sel && !rom_sel)
		else $error("normal fetch not served by RAM");
	a_data_ram_boot: assert property (data_wr && clk_en && !boot_map_switch && data_addr <= 16'h1fff |=> data_ram_we)
		else $error("boot mode RAM write dropped");
	a_code_ram_lock: assert property (data_wr && clk_en && boot_map_switch && data_addr <= 16'h1fff |=> !data_ram_we)
		else $error("code RAM written in normal mode");
	a_io_window: assert property (data_go && data_addr >= 16'hfd80 |=> io_sel && !data_ram_sel)
		else $error("IO window not selected");
	// ==========================================
	// Control state
	a_switch_sticky: assert property (boot_map_switch |=> boot_map_switch)
		else $error("map switch cleared without reset");
	a_attach_order: assert property (bus_attach |-> boot_map_switch)
		else $error("attached before map switch");
	a_reset_clear: assert property ($fell(rst) |-> !boot_map_switch && !bus_attach)
		else $error("state not cleared by reset");
	a_rev_read: assert property (reg_rd && clk_en && reg_addr == 8'h90 |=> reg_rdata[4:1] == REVISION && !reg_rdata[5])
		else $error("revision field wrong");
	a_rdata_idle: assert property (!reg_rd && clk_en |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	c_norm_fetch: cover property (code_go && boot_map_switch);
	c_lock_write: cover property (data_wr && clk_en && boot_map_switch);
	c_attached: cover property (bus_attach);
endmodule // bmr_top_props

bind bmr_top bmr_top_props #(.REVISION(REVISION)) u_props (.ref_clk, .rst, .clk_en, .reg_rd, .code_req, .data_rd,
	.data_wr, .reg_addr, .reg_rdata, .code_addr, .data_addr, .rom_sel, .code_ram_sel, .data_ram_sel, .data_ram_we,
	.io_sel, .boot_map_switch, .bus_attach);

// File: dv/bmr_boot_model.sv
module bmr_boot_model #(
	parameter bit SIG_FOUND   = 1'b1,  // EEPROM holds a signature
	parameter int LOAD_CYCLES = 6      // length of the firmware copy
) (
	input  wire logic        ref_clk,        // core clock
	input  wire logic        rst,            // reset
	output logic             code_req,       // first fetch strobe
	output logic      [15:0] code_addr,      // fetch address
	output logic             eeprom_sig_ok,  // signature result
	output logic             load_done       // loading finished
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	assign code_addr = bmr_pkg::RESET_VECTOR;
	assign eeprom_sig_ok = SIG_FOUND;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt <= 0;
			code_req <= 1'b0;
			load_done <= 1'b0;
		end else begin
			code_req <= (cnt == 0);
			load_done <= (cnt == LOAD_CYCLES);
			if (cnt <= LOAD_CYCLES) cnt <= cnt + 1;
		end
	end
endmodule // bmr_boot_model

// File: dv/bmr_tb_top.sv
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
module bmr_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [3:0] REV = 4'h5;  // arbitrary revision
	typedef struct packed {logic [1:0] k; logic [15:0] a; logic [4:0] e;} bmr_row_type;
	logic        ref_clk = 0, rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, data_rd = 0, data_wr = 0, tb_req = 0;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
	logic [15:0] tb_addr = 16'h0000, data_addr = 16'h0000;
	wire logic   m_req, sig_ok, ld_done, rom_sel, cram, dram, dwe, io_sel, sw, att, usb;
	wire logic [15:0] m_addr;
	wire logic [7:0]  rdata;
	wire logic [12:0] mem_addr;
	wire logic [2:0]  phase;
	wire logic [4:0]  sel = {rom_sel, cram, dram, dwe, io_sel};
	int err_total = 0, check_count = 0;
	// Rows 0..11 boot mode, 12.. normal mode
	bmr_row_type rows [19] = '{
		'{0, 16'h0000, 5'h10}, '{0, 16'h17ff, 5'h10}, '{0, 16'h1800, 5'h00}, '{0, 16'h8000, 5'h10},
		'{0, 16'h97ff, 5'h10}, '{0, 16'h9800, 5'h00}, '{1, 16'h1fff, 5'h04}, '{2, 16'h0000, 5'h06},
		'{1, 16'h2000, 5'h00}, '{1, 16'hfd80, 5'h01}, '{2, 16'hffff, 5'h01}, '{1, 16'hfd7f, 5'h00},
		'{0, 16'h0000, 5'h08}, '{0, 16'h1fff, 5'h08}, '{0, 16'h17ff, 5'h08}, '{0, 16'h8000, 5'h10},
		'{2, 16'h0000, 5'h00}, '{2, 16'h1fff, 5'h00}, '{1, 16'hff90, 5'h01}};
	bmr_boot_model model (.ref_clk(ref_clk), .rst(rst), .code_req(m_req), .code_addr(m_addr),
		.eeprom_sig_ok(sig_ok), .load_done(ld_done));
	bmr_top #(.REVISION(REV)) uut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
		.code_addr(m_req ? m_addr : tb_addr), .code_req(tb_req | m_req), .data_addr(data_addr),
		.data_rd(data_rd), .data_wr(data_wr), .eeprom_sig_ok(sig_ok), .load_done(ld_done), .rom_sel(rom_sel),
		.code_ram_sel(cram), .data_ram_sel(dram), .data_ram_we(dwe), .io_sel(io_sel), .mem_addr(mem_addr),
		.boot_map_switch(sw), .bus_attach(att), .boot_from_usb(usb), .boot_phase(phase));
	initial forever #50 ref_clk = ~ref_clk;
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
		@(posedge ref_clk); reg_wr <= 1'b0; #1;
	endtask
	task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk); reg_rd <= 1'b1; reg_addr <= a;
		@(posedge ref_clk); reg_rd <= 1'b0; #1;
		`CHK(rdata, e)
	endtask
	task automatic acc(input logic [1:0] k, input logic [15:0] a);
		@(posedge ref_clk); tb_req <= (k == 2'd0); data_rd <= (k == 2'd1); data_wr <= (k == 2'd2);
		tb_addr <= a; data_addr <= a;
		@(posedge ref_clk); tb_req <= 1'b0; data_rd <= 1'b0; data_wr <= 1'b0; #1;
	endtask
	task automatic do_reset();
		@(posedge ref_clk); rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask
	task automatic complete_run();
		if (err_total == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ==========================================
	// Sequence
	initial begin
		do_reset();
		`CHK({sw, att, rdata}, 10'h000)
		`CHK(usb, 1'b0)
		reg_read(bmr_pkg::CFG_REG_ADDR, {3'b000, REV, 1'b0});
		foreach (rows[i]) begin
			if (i == 12) reg_write(bmr_pkg::CFG_REG_ADDR, 8'h01);
			acc(rows[i].k, rows[i].a);
			`CHK(sel, rows[i].e)
			if (rows[i].e[4:1] != 4'h0) `CHK(mem_addr, rows[i].a[12:0])
		end
		reg_write(bmr_pkg::CFG_REG_ADDR, 8'h00);
		`CHK(sw, 1'b1)
		reg_write(bmr_pkg::CFG_REG_ADDR, 8'hff);
		reg_read(bmr_pkg::CFG_REG_ADDR, {3'b110, REV, 1'b1});
		reg_read(8'h55, 8'h00);
		reg_write(bmr_pkg::CTL_REG_ADDR, 8'h80);
		`CHK(att, 1'b1)
		do_reset();
		`CHK({sw, att}, 2'b00)
		`CHK(phase, bmr_pkg::BS_LOAD)
		reg_write(bmr_pkg::CTL_REG_ADDR, 8'h80);
		`CHK(att, 1'b0)
		@(posedge ref_clk); clk_en <= 1'b0;
		reg_write(bmr_pkg::CFG_REG_ADDR, 8'h01);
		`CHK(sw, 1'b0)
		@(posedge ref_clk); clk_en <= 1'b1;
		reg_read(bmr_pkg::CFG_REG_ADDR, {3'b000, REV, 1'b0});
		complete_run();
	end
	// Hang guard
	initial begin
		repeat (5000) @(posedge ref_clk);
		err_total++;
		complete_run();
	end
endmodule // bmr_tb_top
